/* File: rtl/pop_seq_defines.svh */
/*
 * Constants of the output driver pop sequencer: register offsets, field
 * positions, reset values and the nominal timing figures.
 * Assumes it is pulled in by the package and by nothing that redefines it.
 */
`ifndef POP_SEQ_DEFINES_SVH
`define POP_SEQ_DEFINES_SVH

// Register offsets within the page.
`define POP_REMOVAL_ADDR 8'h21
`define SPK_WAIT_ADDR 8'h22
`define ROUTING_ADDR 8'h23

// Reset values of the three registers.
`define POP_REMOVAL_RST 8'h3e
`define SPK_WAIT_RST 8'h00
`define ROUTING_RST 8'h00

// Field positions.
`define ORDER_BIT 7
`define PON_MSB 6
`define PON_LSB 3
`define STEP_MSB 2
`define STEP_LSB 1
`define CM_SRC_BIT 0
`define SPK_WAIT_MSB 6
`define SPK_WAIT_LSB 4
`define DAC_ROUTE_MSB 7
`define DAC_ROUTE_LSB 6
`define MIC1_BIT 5
`define MIC2_BIT 4

// Nominal oscillator rate in kHz.
`define OSC_NOM_KHZ 8200

// Driver power-on times in tenths of a microsecond.
`define PON_T0 0
`define PON_T1 153
`define PON_T3 15300
`define PON_T4 153000
`define PON_T5 762000
`define PON_T6 1530000
`define PON_T7 3040000
`define PON_T8 6100000
`define PON_T10 30400000
`define PON_T11 61000000

// Ramp step times in tenths of a microsecond.
`define STEP_T1 9800
`define STEP_T2 19500
`define STEP_T3 39000

// Speaker power-up wait times in tenths of a microsecond.
`define SPK_T1 30400
`define SPK_T2 76200
`define SPK_T3 122000
`define SPK_T4 153000
`define SPK_T5 198000
`define SPK_T6 244000
`define SPK_T7 305000

`endif

/* File: rtl/pop_seq_pkg.sv */
/*
 * Types and time lookups of the output driver pop sequencer.
 * Assumes the defines header is on the include path.
 */
package pop_seq_pkg;
    `include "pop_seq_defines.svh"

    // One-hot sequencer states.
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_PON  = 7'b0000010,
        ST_SPK  = 7'b0000100,
        ST_RAMP = 7'b0001000,
        ST_ON   = 7'b0010000,
        ST_RDN  = 7'b0100000,
        ST_DACW = 7'b1000000
    } seq_state_t;

    // Power-on time of a code; reserved codes fall back to the longest.
    function automatic int pon_time(input logic [3:0] code);
        case (code)
            4'h0: pon_time = `PON_T0;
            4'h1, 4'h2: pon_time = `PON_T1;
            4'h3: pon_time = `PON_T3;
            4'h4: pon_time = `PON_T4;
            4'h5: pon_time = `PON_T5;
            4'h6: pon_time = `PON_T6;
            4'h7: pon_time = `PON_T7;
            4'h8, 4'h9: pon_time = `PON_T8;
            4'ha: pon_time = `PON_T10;
            default: pon_time = `PON_T11;
        endcase
    endfunction

    // Ramp step time of a code.
    function automatic int step_time(input logic [1:0] code);
        case (code)
            2'h1: step_time = `STEP_T1;
            2'h2: step_time = `STEP_T2;
            2'h3: step_time = `STEP_T3;
            default: step_time = 0;
        endcase
    endfunction

    // Speaker wait time of a code.
    function automatic int spk_time(input logic [2:0] code);
        case (code)
            3'h1: spk_time = `SPK_T1;
            3'h2: spk_time = `SPK_T2;
            3'h3: spk_time = `SPK_T3;
            3'h4: spk_time = `SPK_T4;
            3'h5: spk_time = `SPK_T5;
            3'h6: spk_time = `SPK_T6;
            3'h7: spk_time = `SPK_T7;
            default: spk_time = 0;
        endcase
    endfunction

    // Oscillator ticks for a time, rounded up before the division by div, at least one when nonzero.
    function automatic int ticks(input int t01us, input int khz,
                                 input int div);
        longint c;
        c = (longint'(t01us) * longint'(khz) + 64'sd9999) / 64'sd10000;
        c = c / longint'(div);
        if (t01us != 0 && c == 0) begin
            c = 1;
        end
        ticks = int'(c);
    endfunction
endpackage

/* File: rtl/pop_tick_timer.sv */
/*
 * Down-counter that measures a time in oscillator ticks.
 * Assumes osc_tick is a one-cycle pulse already on the clk domain.
 */
`timescale 1ns/1ns
module pop_tick_timer #(
    parameter int CNT_W = 26
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Tick and load.
    input wire logic osc_tick,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    // Status.
    output logic done_r,
    output logic busy_r
);
    logic [CNT_W-1:0] cnt_r; // Ticks still to wait.

    // A load restarts the count; a zero load finishes on the next edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (load) begin
            cnt_r <= load_val;
            busy_r <= (load_val != '0);
            done_r <= (load_val == '0);
        end else if (busy_r && osc_tick) begin
            // Only oscillator ticks advance the count.
            if (cnt_r <= CNT_W'(1)) begin
                cnt_r <= '0;
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r - CNT_W'(1);
                done_r <= 1'b0;
            end
        end else begin
            done_r <= 1'b0;
        end
    end
endmodule

/* File: rtl/pop_sequencer.sv */
/*
 * Output driver pop sequencer: the three pop-removal registers, the
 * routing outputs they steer, and the power-up / power-down sequence.
 * Assumes a register port on clk with the page already selected, one-cycle
 * power-up and power-down requests from clk logic, and the free-running
 * internal oscillator on osc_in, asynchronous to clk.
 */
// What this block does
// - Order bit 0: converter off with amplifiers.
// - Order bit 1: converter off after amplifiers.
// - Four-bit power-on delay code table, reset 0111.
// - Two-bit ramp step time code, reset 11.
// - All times counted on the internal oscillator.
// - Three-bit speaker wait code table, reset 000.
// - Converter route: none, mixer, headphone driver.
// - D5 connects first positive mic input.
// - D4 connects second positive mic input.
// - Common-mode bit 0 selects analog supply divider.
`timescale 1ns/1ns
`include "pop_seq_defines.svh"
module pop_sequencer
    import pop_seq_pkg::*;
#(
    parameter int OSC_KHZ = `OSC_NOM_KHZ,
    parameter int SCALE_DIV = 1,
    parameter int CNT_W = 26,
    parameter int GAIN_W = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    // Sequence requests and gain target.
    input wire logic pwr_up_req,
    input wire logic pwr_down_req,
    input wire logic [GAIN_W-1:0] gain_target,
    // Internal oscillator.
    input wire logic osc_in,
    // Power and gain outputs.
    output logic dac_pwr_r,
    output logic headphone_amplifier_en_r,
    output logic speaker_amplifier_en_r,
    output logic [GAIN_W-1:0] drv_gain_r,
    output logic gain_applied_r,
    // Routing outputs.
    output logic dac_to_mixer_r,
    output logic dac_to_headphone_output_driver_r,
    output logic first_positive_mic_input_to_mixer_r,
    output logic second_positive_mic_input_to_mixer_r,
    output logic cm_from_analog_supply_divider_r
);
    // The longest time must fit the counter; a zero rate cannot be served.
    if (OSC_KHZ < 1 || SCALE_DIV < 1 || GAIN_W < 1 ||
        longint'(ticks(`PON_T11, OSC_KHZ, SCALE_DIV)) >= (64'sd1 <<< CNT_W))
    begin : g_bad_params
        $error("pop_sequencer: parameters cannot be served");
    end

    logic [7:0] pop_cfg_r; // Order, power-on code, step code, cm source.
    logic [7:0] spk_cfg_r; // Speaker wait code and reserved bits.
    logic [7:0] route_cfg_r; // Converter and microphone routing.
    logic osc_s1_r, osc_s2_r, osc_s3_r; // Oscillator synchroniser.
    logic osc_tick; // One clk cycle per oscillator rising edge.
    seq_state_t state_r, state_nxt; // Sequencer state.
    logic tmr_load; // Restart the timer this cycle.
    logic [CNT_W-1:0] tmr_val; // Ticks to load.
    logic tmr_done; // Timer expired last cycle.
    logic [GAIN_W-1:0] gain_tgt_r; // Target latched at power-up.

    // Register writes; reserved bits keep what software wrote.
    // Software is trusted to keep reserved codes out.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pop_cfg_r <= `POP_REMOVAL_RST;
            spk_cfg_r <= `SPK_WAIT_RST;
            route_cfg_r <= `ROUTING_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `POP_REMOVAL_ADDR: pop_cfg_r <= reg_wdata;
                `SPK_WAIT_ADDR: spk_cfg_r <= reg_wdata;
                `ROUTING_ADDR: route_cfg_r <= reg_wdata;
                default: pop_cfg_r <= pop_cfg_r;
            endcase
        end
    end

    // Register reads are registered; other offsets read as zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `POP_REMOVAL_ADDR: reg_rdata_r <= pop_cfg_r;
                `SPK_WAIT_ADDR: reg_rdata_r <= spk_cfg_r;
                `ROUTING_ADDR: reg_rdata_r <= route_cfg_r;
                default: reg_rdata_r <= 8'h00;
            endcase
        end
    end

    // Routing decode; the reserved converter code connects nothing.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_to_mixer_r <= 1'b0;
            dac_to_headphone_output_driver_r <= 1'b0;
            first_positive_mic_input_to_mixer_r <= 1'b0;
            second_positive_mic_input_to_mixer_r <= 1'b0;
            cm_from_analog_supply_divider_r <= 1'b1;
        end else begin
            dac_to_mixer_r <= (route_cfg_r[`DAC_ROUTE_MSB:`DAC_ROUTE_LSB]
                               == 2'h1);
            dac_to_headphone_output_driver_r <=
                (route_cfg_r[`DAC_ROUTE_MSB:`DAC_ROUTE_LSB] == 2'h2);
            first_positive_mic_input_to_mixer_r <=
                route_cfg_r[`MIC1_BIT];
            second_positive_mic_input_to_mixer_r <=
                route_cfg_r[`MIC2_BIT];
            // The reserved value 1 leaves no source, which is why weak
            // drive must keep the bit clear.
            cm_from_analog_supply_divider_r <= !pop_cfg_r[`CM_SRC_BIT];
        end
    end

    // Two flops take the oscillator into clk; the third feeds the edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else begin
            osc_s1_r <= osc_in;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end
    assign osc_tick = osc_s2_r && !osc_s3_r;

    // The timer that measures every delay, step and wait.
    pop_tick_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .osc_tick(osc_tick),
        .load(tmr_load),
        .load_val(tmr_val),
        .done_r(tmr_done),
        .busy_r()
    );

    // Next state and timer loads.
    always_comb begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_val = CNT_W'(ticks(step_time(pop_cfg_r[`STEP_MSB:`STEP_LSB]),
                               OSC_KHZ, SCALE_DIV));
        case (state_r)
            ST_IDLE: begin
                if (pwr_up_req) begin
                    // Power-on delay comes first.
                    state_nxt = ST_PON;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(ticks(
                        pon_time(pop_cfg_r[`PON_MSB:`PON_LSB]),
                        OSC_KHZ, SCALE_DIV));
                end
            end
            ST_PON: begin
                if (pwr_down_req) begin
                    state_nxt = ST_RDN;
                end else if (tmr_done) begin
                    state_nxt = ST_SPK;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(ticks(
                        spk_time(spk_cfg_r[`SPK_WAIT_MSB:`SPK_WAIT_LSB]),
                        OSC_KHZ, SCALE_DIV));
                end
            end
            ST_SPK: begin
                if (pwr_down_req) begin
                    state_nxt = ST_RDN;
                end else if (tmr_done) begin
                    state_nxt = (gain_tgt_r == '0) ? ST_ON : ST_RAMP;
                    tmr_load = 1'b1;
                end
            end
            ST_RAMP: begin
                if (pwr_down_req) begin
                    state_nxt = ST_RDN;
                    tmr_load = 1'b1;
                end else if (tmr_done) begin
                    // Each step holds for the programmed step time.
                    if (drv_gain_r + GAIN_W'(1) == gain_tgt_r) begin
                        state_nxt = ST_ON;
                    end else begin
                        tmr_load = 1'b1;
                    end
                end
            end
            ST_ON: begin
                if (pwr_down_req) begin
                    state_nxt = ST_RDN;
                    tmr_load = 1'b1;
                end
            end
            ST_RDN: begin
                if (drv_gain_r == '0) begin
                    // Amplifiers are off; the order bit picks the converter.
                    state_nxt = pop_cfg_r[`ORDER_BIT] ? ST_DACW : ST_IDLE;
                end else if (tmr_done) begin
                    tmr_load = 1'b1;
                end
            end
            ST_DACW: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Gain stepping and the target latch.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drv_gain_r <= '0;
            gain_tgt_r <= '0;
            gain_applied_r <= 1'b0;
        end else begin
            if (state_r == ST_IDLE && pwr_up_req) begin
                gain_tgt_r <= gain_target;
            end
            if (state_r == ST_RAMP && tmr_done && !pwr_down_req) begin
                drv_gain_r <= drv_gain_r + GAIN_W'(1);
            end else if (state_r == ST_RDN && tmr_done &&
                         drv_gain_r != '0) begin
                drv_gain_r <= drv_gain_r - GAIN_W'(1);
            end
            gain_applied_r <= (state_nxt == ST_ON);
        end
    end

    // Converter and amplifier power. A power-down while still ramping
    // walks the gain back down before anything switches off.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_pwr_r <= 1'b0;
            headphone_amplifier_en_r <= 1'b0;
            speaker_amplifier_en_r <= 1'b0;
        end else begin
            if (state_r == ST_IDLE && pwr_up_req) begin
                dac_pwr_r <= 1'b1;
            end
            if (state_r == ST_SPK && tmr_done && !pwr_down_req) begin
                headphone_amplifier_en_r <= 1'b1;
                speaker_amplifier_en_r <= 1'b1;
            end
            if (state_r == ST_RDN && drv_gain_r == '0) begin
                headphone_amplifier_en_r <= 1'b0;
                speaker_amplifier_en_r <= 1'b0;
                if (!pop_cfg_r[`ORDER_BIT]) begin
                    dac_pwr_r <= 1'b0;
                end
            end
            if (state_r == ST_DACW) begin
                dac_pwr_r <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_ORDER0_TOGETHER: assert property (
        ($fell(headphone_amplifier_en_r) && !pop_cfg_r[`ORDER_BIT])
        |-> !dac_pwr_r && !speaker_amplifier_en_r)
        else $error("converter not off with amplifiers");
    AST_ORDER1_AFTER: assert property (
        ($fell(headphone_amplifier_en_r) && pop_cfg_r[`ORDER_BIT])
        |-> dac_pwr_r ##1 !dac_pwr_r)
        else $error("converter not held until amplifiers off");
    AST_PON_LOAD: assert property (
        (state_r == ST_IDLE && pwr_up_req) |-> tmr_load && tmr_val ==
        CNT_W'(ticks(pon_time(pop_cfg_r[`PON_MSB:`PON_LSB]),
                     OSC_KHZ, SCALE_DIV)))
        else $error("power-on delay not loaded");
    AST_STEP_LOAD: assert property (
        (state_r == ST_ON && pwr_down_req) |-> tmr_val ==
        CNT_W'(ticks(step_time(pop_cfg_r[`STEP_MSB:`STEP_LSB]),
                     OSC_KHZ, SCALE_DIV)))
        else $error("step time not loaded");
    AST_TICK_ONLY: assert property (
        tmr_done |-> $past(osc_tick) || $past(tmr_load))
        else $error("timer expired without an oscillator tick");
    AST_SPK_LOAD: assert property (
        (state_r == ST_PON && state_nxt == ST_SPK) |-> tmr_val ==
        CNT_W'(ticks(spk_time(spk_cfg_r[`SPK_WAIT_MSB:`SPK_WAIT_LSB]),
                     OSC_KHZ, SCALE_DIV)))
        else $error("speaker wait not loaded");
    AST_DAC_ROUTE: assert property (
        ##1 (dac_to_mixer_r == ($past(route_cfg_r[7:6]) == 2'h1)) &&
        (dac_to_headphone_output_driver_r ==
         ($past(route_cfg_r[7:6]) == 2'h2)))
        else $error("converter route wrong");
    AST_MIC1: assert property (
        ##1 first_positive_mic_input_to_mixer_r == $past(route_cfg_r[5]))
        else $error("first mic route wrong");
    AST_MIC2: assert property (
        ##1 second_positive_mic_input_to_mixer_r == $past(route_cfg_r[4]))
        else $error("second mic route wrong");
    AST_CM_SRC: assert property (
        !pop_cfg_r[`CM_SRC_BIT] |=> cm_from_analog_supply_divider_r)
        else $error("common mode not from divider");
    AST_RAMP_STEP: assert property (
        $rose(drv_gain_r != '0) |-> $past(state_r == ST_RAMP && tmr_done)
        && headphone_amplifier_en_r)
        else $error("gain stepped outside the ramp");

    COV_POWER_UP: cover property (state_r == ST_RAMP ##1 state_r == ST_ON);
    COV_DOWN_ORDER0: cover property (state_r == ST_RDN ##1 state_r == ST_IDLE);
    COV_DOWN_ORDER1: cover property (state_r == ST_DACW);
endmodule

/* File: bench/pop_sequencer_tb.sv */
/*
 * Self-checking testbench of the output driver pop sequencer: register
 * reset values and readback, routing outputs, and full power cycles.
 * Assumes the package and the defines header are compiled first. The
 * oscillator is made here at a quarter of clk.
 */
`timescale 1ns/1ns
`include "pop_seq_defines.svh"
module pop_sequencer_tb;
    import pop_seq_pkg::*;
    // Tick counts are divided so that the longest delay stays short.
    localparam int DIV = 10000;
    localparam int KHZ = 8200;
    localparam int OSC_CLKS = 4;
    localparam int LIM = 20000;
    // Nominal times in tenths of a microsecond, indexed by field code.
    localparam longint PON_TAB [12] = '{0, `PON_T1, `PON_T1, `PON_T3,
        `PON_T4, `PON_T5, `PON_T6, `PON_T7, `PON_T8, `PON_T8,
        `PON_T10, `PON_T11};
    localparam longint STEP_TAB [4] = '{0, `STEP_T1, `STEP_T2, `STEP_T3};
    localparam longint SPK_TAB [8] = '{0, `SPK_T1, `SPK_T2, `SPK_T3,
        `SPK_T4, `SPK_T5, `SPK_T6, `SPK_T7};
    // Stimulus, all given a value at time zero.
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic pwr_up_req = 1'b0;
    logic pwr_down_req = 1'b0;
    logic [3:0] gain_target = 4'h0;
    logic osc_in = 1'b0;
    logic osc_div = 1'b0; // Halves clk once more for the oscillator.
    // Observed outputs.
    logic [7:0] reg_rdata_r;
    logic dac_pwr_r, hp_en, sp_en, gain_applied_r;
    logic [3:0] drv_gain_r;
    logic mix_r, hpd_r, mic1_r, mic2_r, cm_r;
    int fails = 0;
    int n_compared = 0;
    int seed_v;

    pop_sequencer #(.OSC_KHZ(KHZ), .SCALE_DIV(DIV)) dut_u (
        .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_r(reg_rdata_r), .pwr_up_req(pwr_up_req),
        .pwr_down_req(pwr_down_req), .gain_target(gain_target),
        .osc_in(osc_in), .dac_pwr_r(dac_pwr_r),
        .headphone_amplifier_en_r(hp_en), .speaker_amplifier_en_r(sp_en),
        .drv_gain_r(drv_gain_r), .gain_applied_r(gain_applied_r),
        .dac_to_mixer_r(mix_r), .dac_to_headphone_output_driver_r(hpd_r),
        .first_positive_mic_input_to_mixer_r(mic1_r),
        .second_positive_mic_input_to_mixer_r(mic2_r),
        .cm_from_analog_supply_divider_r(cm_r));

    // Clock of 40 ns period.
    always #20 clk = ~clk;
    // Oscillator at a quarter of clk, safely below the synchroniser limit.
    // The pin toggles every second edge, so one rising edge per four clk.
    always @(posedge clk) begin
        osc_div <= ~osc_div;
        if (osc_div) begin
            osc_in <= ~osc_in;
        end
    end

    // Expected tick count, rounded up before the division by DIV, at least one when nonzero.
    function automatic int tk(input longint t);
        longint c;
        c = (t * KHZ + 9999) / 10000 / DIV;
        if (t != 0 && c == 0) begin
            c = 1;
        end
        return int'(c);
    endfunction

    // True when two cycle counts agree within a tolerance.
    function automatic logic near(input int a, input int b, input int tol);
        return (a - b <= tol) && (b - a <= tol);
    endfunction

    // Selected status for the bounded waits.
    function automatic logic sig(input int w);
        case (w)
            0: return hp_en & sp_en;
            1: return gain_applied_r;
            default: return dac_pwr_r;
        endcase
    endfunction

    // Ends the run with the verdict.
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register write, one cycle strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One register read; data is taken once it has settled.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata_r;
    endtask

    // Waits for a status level; running out of cycles ends the run.
    task automatic wait_sig(input int w, input logic lvl, output int n);
        n = 0;
        while (sig(w) !== lvl) begin
            if (n >= LIM) begin
                fails++;
                $display("ERROR at %0t: wait ran out", $time);
                close_out();
            end
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // Full power-up then power-down with the given field codes.
    task automatic pu(input logic [3:0] pon, input logic [1:0] stp,
                      input logic [2:0] spk, input logic ord,
                      input logic [3:0] tgt);
        int n, e, amp_c, dac_c, i;
        wr(8'h21, {ord, pon, stp, 1'b0});
        wr(8'h22, {1'b0, spk, 4'h0});
        @(posedge clk);
        pwr_up_req <= 1'b1;
        gain_target <= tgt;
        @(posedge clk);
        pwr_up_req <= 1'b0;
        #1;
        chk(dac_pwr_r, 1'b1);
        wait_sig(0, 1'b1, n);
        e = (tk(PON_TAB[pon]) + tk(SPK_TAB[spk])) * OSC_CLKS;
        chk(near(n, e, 16), 1'b1);
        wait_sig(1, 1'b1, n);
        chk(drv_gain_r, tgt);
        e = tgt * tk(STEP_TAB[stp]) * OSC_CLKS;
        chk(near(n, e, 6 * tgt + 8), 1'b1);
        @(posedge clk);
        pwr_down_req <= 1'b1;
        @(posedge clk);
        pwr_down_req <= 1'b0;
        amp_c = -1;
        dac_c = -1;
        // Record the cycles at which the amplifiers and converter drop.
        for (i = 0; i < LIM && (amp_c < 0 || dac_c < 0); i++) begin
            #1;
            if (amp_c < 0 && !(hp_en | sp_en)) begin
                amp_c = i;
                chk(drv_gain_r, 4'h0);
            end
            if (dac_c < 0 && !dac_pwr_r) begin
                dac_c = i;
            end
            @(posedge clk);
        end
        if (i >= LIM) begin
            fails++;
            $display("ERROR at %0t: power-down ran out", $time);
            close_out();
        end
        chk(dac_c - amp_c, ord);
        $display("test cycle pon %0d step %0d spk %0d order %0d done",
                 pon, stp, spk, ord);
    endtask

    // Main sequence.
    initial begin
        logic [7:0] d, v, u;
        int i;
        seed_v = $urandom(32'hb945d79d);
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(cm_r, 1'b1);
        chk({mix_r, hpd_r, mic1_r, mic2_r}, 4'h0);
        rd(8'h21, d);
        chk(d, 8'h3e);
        rd(8'h22, d);
        chk(d, 8'h00);
        rd(8'h23, d);
        chk(d, 8'h00);
        // An unmapped place reads zero and leaves the map untouched.
        wr(8'h24, 8'h5a);
        rd(8'h24, d);
        chk(d, 8'h00);
        rd(8'h21, d);
        chk(d, 8'h3e);
        $display("test reset and map done");
        // Every converter route with random microphone bits.
        for (i = 0; i < 8; i++) begin
            v = {2'(i), 2'($urandom), 4'h0};
            wr(8'h23, v);
            rd(8'h23, d);
            chk(d, v);
            chk(mix_r, v[7:6] == 2'b01);
            chk(hpd_r, v[7:6] == 2'b10);
            chk(mic1_r, v[5]);
            chk(mic2_r, v[4]);
        end
        $display("test routing done");
        // Random legal field values read back whole.
        for (i = 0; i < 4; i++) begin
            // Power-on codes stay below 1100, cm bit clear.
            v = {1'($urandom), 4'($urandom % 12), 2'($urandom), 1'b0};
            u = {1'b0, 3'($urandom), 4'h0};
            wr(8'h21, v);
            wr(8'h22, u);
            rd(8'h21, d);
            chk(d, v);
            rd(8'h22, d);
            chk(d, u);
            chk(cm_r, 1'b1);
        end
        $display("test readback done");
        // Corner cases first, then random power cycles.
        pu(4'h0, 2'h0, 3'h0, 1'b0, 4'h1);
        pu(4'h1, 2'h1, 3'h1, 1'b1, 4'hf);
        pu(4'h3, 2'h2, 3'h7, 1'b0, 4'h3);
        pu(4'h7, 2'h3, 3'h2, 1'b1, 4'h2);
        for (i = 0; i < 4; i++) begin
            pu(4'($urandom % 7), 2'($urandom), 3'($urandom), 1'($urandom),
               4'(1 + $urandom % 15));
        end
        // A second reset in mid-run restores the defaults.
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h21, d);
        chk(d, 8'h3e);
        $display("test second reset done");
        close_out();
    end
endmodule
